// ==== rtl/bsfu_consts.vh ====
// Constants for the bit, shift and flag instruction unit.
// Assumes the decoder delivers the operation codes listed here.
`ifndef BSFU_CONSTS_VH
`define BSFU_CONSTS_VH

// ----------------------------------------
// Operation codes from the decoder
// ----------------------------------------
`define BSFU_OP_W 4
`define BSFU_OP_NOP 4'h0
`define BSFU_OP_IOSET 4'h1
`define BSFU_OP_IOCLR 4'h2
`define BSFU_OP_LSL 4'h3
`define BSFU_OP_LSR 4'h4
`define BSFU_OP_ROL 4'h5
`define BSFU_OP_ROR 4'h6
`define BSFU_OP_ASR 4'h7
`define BSFU_OP_SWAP 4'h8
`define BSFU_OP_FSET 4'h9
`define BSFU_OP_FCLR 4'ha
`define BSFU_OP_TSTORE 4'hb
`define BSFU_OP_TLOAD 4'hc
`define BSFU_OP_SLEEP 4'hd
`define BSFU_OP_WDR 4'he
`define BSFU_OP_PMLINC 4'hf

// ----------------------------------------
// Status flag positions and reset value
// ----------------------------------------
`define BSFU_SR_C 0
`define BSFU_SR_Z 1
`define BSFU_SR_N 2
`define BSFU_SR_V 3
`define BSFU_SR_S 4
`define BSFU_SR_H 5
`define BSFU_SR_T 6
`define BSFU_SR_I 7
`define BSFU_SR_RST 8'h00

// ----------------------------------------
// Timing in clock cycles
// ----------------------------------------
`define BSFU_ALU_CYCLES 1
`define BSFU_IO_CYCLES 2

`endif

// ==== rtl/bsfu_shifter.v ====
// Shift, rotate, swap and T-to-bit datapath, purely combinational.
// Assumes the operand and carry are stable in the cycle of acceptance.
`timescale 1ns/1ps
`default_nettype none
`include "bsfu_consts.vh"

module bsfu_shifter (
   input wire [3:0] opCode, // Operation code
   input wire [7:0] dIn, // Register operand
   input wire [2:0] bitSel, // Bit index for T-to-bit
   input wire cIn, // Current carry flag
   input wire tIn, // Current T flag
   output reg [7:0] res, // Result byte
   output reg cOut, // Carry out of a shift
   output reg isShift, // Shift updates Z,C,N,V
   output reg wrReg // Result goes to the register file
);

   always @* begin
      res = dIn;
      cOut = cIn;
      isShift = 1'b0;
      wrReg = 1'b0;
      case (opCode)
         `BSFU_OP_LSL: begin
            res = {dIn[6:0], 1'b0};
            cOut = dIn[7];
            isShift = 1'b1;
            wrReg = 1'b1;
         end
         `BSFU_OP_LSR: begin
            res = {1'b0, dIn[7:1]};
            cOut = dIn[0];
            isShift = 1'b1;
            wrReg = 1'b1;
         end
         `BSFU_OP_ROL: begin
            res = {dIn[6:0], cIn};
            cOut = dIn[7];
            isShift = 1'b1;
            wrReg = 1'b1;
         end
         `BSFU_OP_ROR: begin
            res = {cIn, dIn[7:1]};
            cOut = dIn[0];
            isShift = 1'b1;
            wrReg = 1'b1;
         end
         `BSFU_OP_ASR: begin
            res = {dIn[7], dIn[7:1]};
            cOut = dIn[0];
            isShift = 1'b1;
            wrReg = 1'b1;
         end
         `BSFU_OP_SWAP: begin
            res = {dIn[3:0], dIn[7:4]};
            wrReg = 1'b1;
         end
         `BSFU_OP_TLOAD: begin
            res[bitSel] = tIn;
            wrReg = 1'b1;
         end
         default: begin
            res = dIn;
         end
      endcase
   end

endmodule // bsfu_shifter
`default_nettype wire

// ==== rtl/bsfu_flag_ctl.v ====
// Next value of the status flags for one accepted operation.
// Assumes the shifter result and carry belong to the same operation.
`timescale 1ns/1ps
`default_nettype none
`include "bsfu_consts.vh"

module bsfu_flag_ctl (
   input wire [3:0] opCode, // Operation code
   input wire [2:0] bitSel, // Flag or bit index
   input wire [7:0] sregIn, // Current flags
   input wire [7:0] res, // Shifter result
   input wire cOut, // Shifter carry
   input wire isShift, // Shift operation
   input wire stBit, // Selected source bit for T
   output wire [7:0] sregNxt // Flags after the operation
);

   // ----------------------------------------
   // Shift flag values
   // ----------------------------------------
   wire shZ;
   wire shN;
   wire [7:0] shVal;
   wire [7:0] shMask;
   assign shZ = (res == 8'h00);
   assign shN = res[7];
   assign shVal = ({7'h00, cOut} << `BSFU_SR_C) | ({7'h00, shZ} << `BSFU_SR_Z)
      | ({7'h00, shN} << `BSFU_SR_N) | ({7'h00, shN ^ cOut} << `BSFU_SR_V);
   assign shMask = (8'h01 << `BSFU_SR_C) | (8'h01 << `BSFU_SR_Z)
      | (8'h01 << `BSFU_SR_N) | (8'h01 << `BSFU_SR_V);

   wire isSet;
   wire isClr;
   wire isStore;
   assign isSet = (opCode == `BSFU_OP_FSET);
   assign isClr = (opCode == `BSFU_OP_FCLR);
   assign isStore = (opCode == `BSFU_OP_TSTORE);

   // ----------------------------------------
   // Per-flag selection
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : gFlag
         localparam [2:0] IDX = i;
         wire hit;
         assign hit = (bitSel == IDX);
         assign sregNxt[i] = (isSet && hit) ? 1'b1 :
            (isClr && hit) ? 1'b0 :
            (isStore && (i == `BSFU_SR_T)) ? stBit :
            (isShift && shMask[i]) ? shVal[i] :
            sregIn[i];
      end
   endgenerate

endmodule // bsfu_flag_ctl
`default_nettype wire

// ==== rtl/bsfu_unit.v ====
// Bit, shift and flag instruction unit of an 8-bit core.
// Assumes the decoder presents one operation with opValid, that regData is
// the already-read register operand, and that the I/O space returns
// ioRdData combinationally in the cycle ioRdEn is high. All inputs come
// from logic on clk, so none is synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "bsfu_consts.vh"

module bsfu_unit #(
   parameter IO_AW = 5 // I/O address width reachable by bit ops
) (
   input wire clk, // Core clock
   input wire rstn, // Asynchronous reset, active low
   input wire opValid, // Operation offered by the decoder
   input wire [3:0] opCode, // Operation code
   input wire [2:0] bitSel, // Bit or flag index
   input wire [IO_AW-1:0] ioAddr, // I/O register address
   input wire [7:0] regData, // Register operand
   input wire [7:0] ioRdData, // I/O read data, valid with ioRdEn
   output reg opReady, // Unit can take an operation
   output reg opDone, // Operation finished, one pulse
   output reg regWrEn, // Register file write strobe
   output reg [7:0] regWrData, // Register file write data
   output reg ioRdEn, // I/O read strobe
   output reg ioWrEn, // I/O write strobe
   output reg [IO_AW-1:0] ioAddrOut, // I/O address for read and write
   output reg [7:0] ioWrData, // I/O write data
   output reg [7:0] status_flags_register, // Status flags
   output reg sleepReq, // Hand-off to sleep logic, one pulse
   output reg wdtRestart, // Watchdog restart, one pulse
   output reg lpmRefused // Unsupported load refused, one pulse
);

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   localparam [0:0] ST_IDLE = 1'b0;
   localparam [0:0] ST_IOMOD = 1'b1;

   reg state_r;
   reg state_nxt;
   reg ioSet_r;
   reg ioSet_nxt;
   reg [2:0] ioBit_r;
   reg [2:0] ioBit_nxt;

   // Next values of the output flip-flops
   reg opReady_nxt;
   reg opDone_nxt;
   reg regWrEn_nxt;
   reg [7:0] regWrData_nxt;
   reg ioRdEn_nxt;
   reg ioWrEn_nxt;
   reg [IO_AW-1:0] ioAddrOut_nxt;
   reg [7:0] ioWrData_nxt;
   reg [7:0] status_flags_register_nxt;
   reg sleepReq_nxt;
   reg wdtRestart_nxt;
   reg lpmRefused_nxt;

   // ----------------------------------------
   // Datapath
   // ----------------------------------------
   wire take;
   assign take = opValid && opReady;

   wire [7:0] shRes;
   wire shCarry;
   wire shIsShift;
   wire shWrReg;
   wire [7:0] flagNxt;

   bsfu_shifter uShift (
      .opCode(opCode),
      .dIn(regData),
      .bitSel(bitSel),
      .cIn(status_flags_register[`BSFU_SR_C]),
      .tIn(status_flags_register[`BSFU_SR_T]),
      .res(shRes),
      .cOut(shCarry),
      .isShift(shIsShift),
      .wrReg(shWrReg)
   );

   bsfu_flag_ctl uFlag (
      .opCode(opCode),
      .bitSel(bitSel),
      .sregIn(status_flags_register),
      .res(shRes),
      .cOut(shCarry),
      .isShift(shIsShift),
      .stBit(regData[bitSel]),
      .sregNxt(flagNxt)
   );

   // ----------------------------------------
   // I/O bit merge
   // ----------------------------------------
   // Only the selected bit changes; the rest is written back as read.
   // Bits that hardware alters between read and write are lost, which
   // is the known cost of a read-modify-write.
   wire [7:0] ioMerged;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : gIoBit
         localparam [2:0] IDX = gi;
         assign ioMerged[gi] = (ioBit_r == IDX) ? ioSet_r : ioRdData[gi];
      end
   endgenerate

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      ioSet_nxt = ioSet_r;
      ioBit_nxt = ioBit_r;
      opDone_nxt = 1'b0;
      regWrEn_nxt = 1'b0;
      regWrData_nxt = regWrData;
      ioRdEn_nxt = 1'b0;
      ioWrEn_nxt = 1'b0;
      ioAddrOut_nxt = ioAddrOut;
      ioWrData_nxt = ioWrData;
      status_flags_register_nxt = status_flags_register;
      sleepReq_nxt = 1'b0;
      wdtRestart_nxt = 1'b0;
      lpmRefused_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (take) begin
               case (opCode)
                  `BSFU_OP_IOSET, `BSFU_OP_IOCLR: begin
                     // First cycle reads, second writes; flags untouched
                     state_nxt = ST_IOMOD;
                     ioSet_nxt = (opCode == `BSFU_OP_IOSET);
                     ioBit_nxt = bitSel;
                     ioAddrOut_nxt = ioAddr;
                     ioRdEn_nxt = 1'b1;
                  end
                  `BSFU_OP_SLEEP: begin
                     sleepReq_nxt = 1'b1;
                     opDone_nxt = 1'b1;
                  end
                  `BSFU_OP_WDR: begin
                     wdtRestart_nxt = 1'b1;
                     opDone_nxt = 1'b1;
                  end
                  `BSFU_OP_PMLINC: begin
                     // No load, no pointer update; refusal is reported
                     lpmRefused_nxt = 1'b1;
                     opDone_nxt = 1'b1;
                  end
                  default: begin
                     // Single-cycle register and flag operations
                     regWrEn_nxt = shWrReg;
                     regWrData_nxt = shRes;
                     status_flags_register_nxt = flagNxt;
                     opDone_nxt = 1'b1;
                  end
               endcase
            end
         end
         ST_IOMOD: begin
            ioWrEn_nxt = 1'b1;
            ioWrData_nxt = ioMerged;
            opDone_nxt = 1'b1;
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // Ready is registered, so it drops for the read cycle of an I/O op
      opReady_nxt = (state_nxt == ST_IDLE);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         ioSet_r <= 1'b0;
         ioBit_r <= 3'h0;
         opReady <= 1'b1;
         opDone <= 1'b0;
         regWrEn <= 1'b0;
         regWrData <= 8'h00;
         ioRdEn <= 1'b0;
         ioWrEn <= 1'b0;
         ioAddrOut <= {IO_AW{1'b0}};
         ioWrData <= 8'h00;
         status_flags_register <= `BSFU_SR_RST;
         sleepReq <= 1'b0;
         wdtRestart <= 1'b0;
         lpmRefused <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ioSet_r <= ioSet_nxt;
         ioBit_r <= ioBit_nxt;
         opReady <= opReady_nxt;
         opDone <= opDone_nxt;
         regWrEn <= regWrEn_nxt;
         regWrData <= regWrData_nxt;
         ioRdEn <= ioRdEn_nxt;
         ioWrEn <= ioWrEn_nxt;
         ioAddrOut <= ioAddrOut_nxt;
         ioWrData <= ioWrData_nxt;
         status_flags_register <= status_flags_register_nxt;
         sleepReq <= sleepReq_nxt;
         wdtRestart <= wdtRestart_nxt;
         lpmRefused <= lpmRefused_nxt;
      end
   end

endmodule // bsfu_unit
`default_nettype wire

// ==== verification/bsfu_unit_props.sv ====
// Port checker for the bit, shift and flag instruction unit.
// Assumes the op codes of bsfu_consts.vh and a one-cycle answer to each take, two cycles for I/O bit ops.
`timescale 1ns/1ps
`default_nettype none

module bsfu_unit_props (
   input wire logic clk, // Core clock
   input wire logic rstn, // Reset, active low
   input wire logic opValid, // Op offered
   input wire logic [3:0] opCode, // Op code
   input wire logic [2:0] bitSel, // Bit index
   input wire logic [7:0] regData, // Operand
   input wire logic [7:0] ioRdData, // I/O read data
   input wire logic opReady, // Take possible
   input wire logic opDone, // Op finished
   input wire logic regWrEn, // Register write
   input wire logic [7:0] regWrData, // Register data
   input wire logic ioRdEn, // I/O read
   input wire logic ioWrEn, // I/O write
   input wire logic [7:0] ioWrData, // I/O write data
   input wire logic [7:0] status_flags_register, // Flags
   input wire logic sleepReq, // Sleep hand-off
   input wire logic wdtRestart, // Watchdog restart
   input wire logic lpmRefused // Load refused
);
   // ----------------------------------------
   // Properties, all on the core clock
   // ----------------------------------------
   wire logic take;
   assign take = opValid && opReady;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_io_set_bit: assert property (take && opCode == 4'h1 |=> ioRdEn && !opReady ##1
      ioWrEn && opDone && ioWrData == ($past(ioRdData) | (8'h01 << $past(bitSel, 2))))
      else $error("I/O bit set wrong");
   chk_io_clear_bit: assert property (take && opCode == 4'h2 |=> ioRdEn && !opReady ##1
      ioWrEn && opDone && ioWrData == ($past(ioRdData) & ~(8'h01 << $past(bitSel, 2))))
      else $error("I/O bit clear wrong");
   chk_io_flags_kept: assert property (take && (opCode == 4'h1 || opCode == 4'h2) |=>
      $stable(status_flags_register) [*2]) else $error("I/O bit op changed flags");
   chk_left_shift: assert property (take && opCode == 4'h3 |=> regWrEn &&
      regWrData == {$past(regData[6:0]), 1'b0} && status_flags_register[0] == $past(regData[7]))
      else $error("left shift wrong");
   chk_right_shift: assert property (take && opCode == 4'h4 |=> regWrEn &&
      regWrData == {1'b0, $past(regData[7:1])} && status_flags_register[0] == $past(regData[0]))
      else $error("right shift wrong");
   chk_rotate_left: assert property (take && opCode == 4'h5 |=> regWrEn &&
      regWrData == {$past(regData[6:0]), $past(status_flags_register[0])} && status_flags_register[0] == $past(regData[7]))
      else $error("rotate left wrong");
   chk_rotate_right: assert property (take && opCode == 4'h6 |=> regWrEn &&
      regWrData == {$past(status_flags_register[0]), $past(regData[7:1])} && status_flags_register[0] == $past(regData[0]))
      else $error("rotate right wrong");
   chk_arith_shift: assert property (take && opCode == 4'h7 |=> regWrEn &&
      regWrData == {$past(regData[7]), $past(regData[7:1])} && status_flags_register[0] == $past(regData[0]))
      else $error("arithmetic shift wrong");
   chk_shift_flags: assert property (take && opCode >= 4'h3 && opCode <= 4'h7 |=>
      status_flags_register[1] == (regWrData == 8'h00) && status_flags_register[2] == regWrData[7] &&
      status_flags_register[3] == (status_flags_register[2] ^ status_flags_register[0]) && status_flags_register[7:4] == $past(status_flags_register[7:4]))
      else $error("shift flags wrong");
   chk_t_store: assert property (take && opCode == 4'hb |=> status_flags_register[6] == $past(regData[bitSel])
      && {status_flags_register[7], status_flags_register[5:0]} == $past({status_flags_register[7], status_flags_register[5:0]})) else $error("bit store wrong");
   chk_t_load: assert property (take && opCode == 4'hc |=> regWrEn && $stable(status_flags_register) &&
      regWrData[$past(bitSel)] == $past(status_flags_register[6])) else $error("bit load wrong");
   chk_flag_set: assert property (take && opCode == 4'h9 |=>
      status_flags_register == ($past(status_flags_register) | (8'h01 << $past(bitSel)))) else $error("flag set wrong");
   chk_flag_clear: assert property (take && opCode == 4'ha |=>
      status_flags_register == ($past(status_flags_register) & ~(8'h01 << $past(bitSel)))) else $error("flag clear wrong");
   chk_sleep_issue: assert property (take && opCode == 4'hd |=>
      sleepReq && opDone && $stable(status_flags_register)) else $error("sleep issue wrong");
   chk_wdog_restart: assert property (take && opCode == 4'he |=>
      wdtRestart && opDone && $stable(status_flags_register)) else $error("watchdog restart wrong");
   chk_load_refused: assert property (take && opCode == 4'hf |=>
      lpmRefused && !regWrEn && $stable(status_flags_register)) else $error("refused load had effect");
   chk_swap_nibbles: assert property (take && opCode == 4'h8 |=> regWrEn && $stable(status_flags_register) &&
      regWrData == {$past(regData[3:0]), $past(regData[7:4])}) else $error("swap wrong");
endmodule // bsfu_unit_props

bind bsfu_unit bsfu_unit_props bsfu_unit_props_i (.clk(clk), .rstn(rstn), .opValid(opValid),
   .opCode(opCode), .bitSel(bitSel), .regData(regData), .ioRdData(ioRdData),
   .opReady(opReady), .opDone(opDone), .regWrEn(regWrEn), .regWrData(regWrData),
   .ioRdEn(ioRdEn), .ioWrEn(ioWrEn), .ioWrData(ioWrData), .status_flags_register(status_flags_register),
   .sleepReq(sleepReq), .wdtRestart(wdtRestart), .lpmRefused(lpmRefused));

`default_nettype wire

// ==== verification/bsfu_unit_tb.sv ====
// Self-checking bench for the bit, shift and flag instruction unit.
// Assumes inputs change on the falling edge and outputs settle after the rising one.
`timescale 1ns/1ps
`default_nettype none

module bsfu_unit_tb;
   logic clk, rstn, opValid, opReady, opDone, regWrEn, ioRdEn, ioWrEn;
   logic sleepReq, wdtRestart, lpmRefused;
   logic [3:0] opCode;
   logic [2:0] bitSel;
   logic [4:0] ioAddr, ioAddrOut;
   logic [7:0] regData, ioRdData, regWrData, ioWrData, status_flags_register, es;
   int errors = 0;
   int cmp_count = 0;

   bsfu_unit #(.IO_AW(5)) bsfu_unit_i (.clk(clk), .rstn(rstn), .opValid(opValid),
      .opCode(opCode), .bitSel(bitSel), .ioAddr(ioAddr), .regData(regData),
      .ioRdData(ioRdData), .opReady(opReady), .opDone(opDone), .regWrEn(regWrEn),
      .regWrData(regWrData), .ioRdEn(ioRdEn), .ioWrEn(ioWrEn), .ioAddrOut(ioAddrOut),
      .ioWrData(ioWrData), .status_flags_register(status_flags_register), .sleepReq(sleepReq), .wdtRestart(wdtRestart),
      .lpmRefused(lpmRefused));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One take, then outputs of the answer cycle are settled at return
   task automatic op(input logic [3:0] c, input logic [2:0] b, input logic [7:0] d);
      @(negedge clk);
      opValid = 1'b1;
      opCode = c;
      bitSel = b;
      regData = d;
      @(negedge clk);
      opValid = 1'b0;
   endtask

   task automatic io(input logic [3:0] c, input logic [2:0] b, input logic [7:0] rd,
                     input logic [7:0] x);
      op(c, b, 8'h00);
      ioRdData = rd;
      chk({6'h00, ioRdEn, opReady}, 8'h02);
      chk({3'h0, ioAddrOut}, {3'h0, ioAddr});
      @(negedge clk);
      chk(ioWrData, x);
      chk({6'h00, ioWrEn, opDone}, 8'h03);
      chk(status_flags_register, es);
      ioRdData = ~rd;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_shift;
      logic [7:0] d, r;
      logic [3:0] c;
      logic co;
      for (int k = 0; k < 20; k++) begin
         c = 4'(3 + k % 5);
         d = (k >= 10) ? 8'h01 : 8'h81;
         op(((k / 5) % 2) ? 4'h9 : 4'ha, 3'h0, 8'h00);
         es[0] = (k / 5) % 2;
         case (c)
            4'h3: {co, r} = {d, 1'b0};
            4'h4: {r, co} = {1'b0, d};
            4'h5: {co, r} = {d, es[0]};
            4'h6: {r, co} = {es[0], d};
            default: {r, co} = {d[7], d};
         endcase
         op(c, 3'h0, d);
         es[3:0] = {r[7] ^ co, r[7], r == 8'h00, co};
         chk(regWrData, r);
         chk(status_flags_register, es);
      end
      $display("shift test done");
   endtask

   task automatic t_flags;
      for (int i = 0; i < 16; i++) begin
         op(i < 8 ? 4'h9 : 4'ha, i[2:0], 8'h00);
         es[i % 8] = (i < 8);
         chk(status_flags_register, es);
      end
      $display("flag test done");
   endtask

   // Bit transfer, swap, then read-modify-write at both ends of the byte
   task automatic t_bits;
      op(4'hb, 3'h3, 8'h08);
      es[6] = 1'b1;
      chk(status_flags_register, es);
      op(4'hc, 3'h5, 8'h81);
      chk(regWrData, 8'ha1);
      chk(status_flags_register, es);
      op(4'h8, 3'h0, 8'h3c);
      chk(regWrData, 8'hc3);
      io(4'h1, 3'h2, 8'h50, 8'h54);
      io(4'h2, 3'h7, 8'hff, 8'h7f);
      io(4'h1, 3'h0, 8'h00, 8'h01);
      $display("bit and I/O test done");
   endtask

   task automatic t_misc;
      op(4'hd, 3'h0, 8'h00);
      chk({6'h00, sleepReq, opDone}, 8'h03);
      op(4'he, 3'h0, 8'h00);
      chk({6'h00, wdtRestart, opDone}, 8'h03);
      op(4'hf, 3'h0, 8'h5a);
      chk({6'h00, lpmRefused, regWrEn}, 8'h02);
      chk(status_flags_register, es);
      op(4'h0, 3'h4, 8'h77);
      chk({6'h00, regWrEn, opDone}, 8'h01);
      chk(status_flags_register, es);
      $display("misc test done");
   endtask

   task automatic tally_and_finish;
      $display("compares %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      opValid = 1'b0;
      opCode = 4'h0;
      bitSel = 3'h0;
      ioAddr = 5'h0a;
      regData = 8'h00;
      ioRdData = 8'h00;
      es = 8'h00;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      t_shift;
      t_flags;
      t_bits;
      t_misc;
      tally_and_finish;
   end

   // Whole run is near 140 cycles; this limit only catches a hang
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      tally_and_finish;
   end
endmodule // bsfu_unit_tb

`default_nettype wire
